// File: hdl/banked_io_register_window.sv
/*
 * Banked host register window: sixteen byte locations, a bank selector
 * at the top word, byte-lane enables and 8/16/32-bit host bus widths.
 * Assumes an asynchronous ISA-like host whose strobes, address, lanes
 * and data are held stable while a strobe is low; the width straps are
 * steady around reset release. RO contents come from same-clock logic.
 */
// Summary of operation
// RULE1: Only sixteen byte locations visible; registers spread over banks.
// RULE2: Bank selector at 0xE-0xF decodes identically in every bank.
// RULE3: Writing selector changes decoded bank for all later accesses.
// RULE4: Active-low byte lanes pick bytes; access is 8, 16 or 32 bits.
// RULE5: Same bank layout and offsets for 8, 16 and 32-bit buses.
// RULE6: Full 32-bit reads and writes accepted with all four lanes on.
// RULE7: Window reached over an ISA-like asynchronous host bus.
// RULE8: On 8/16 product, strap 1 selects 16-bit bus, 0 selects 8-bit.
// RULE9: Reserved locations read zero and ignore writes.
`default_nettype none

module banked_io_register_window
    import banked_window_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [3:0] host_addr_i,
    input wire logic [3:0] byte_lane_select_n_i,
    input wire logic [31:0] host_data_i,
    output logic [31:0] host_data_o,
    output logic host_data_oe_o,
    input wire logic host_bus_width_select_i,
    input wire logic bus_is_32bit_i,
    input wire logic [15:0] bus_fault_status_i,
    input wire logic [15:0] memory_selftest_info_i,
    output logic [15:0] bank_selector_o,
    output logic [15:0] base_address_o,
    output logic [15:0] rx_flow_watermark_o,
    output logic [15:0] bus_burst_size_o,
    output logic [47:0] host_station_addr_o,
    output logic [15:0] onchip_bus_control_o,
    output logic [15:0] chip_reset_control_o,
    output logic [15:0] bus_setup_o
);
    import banked_window_pkg::*;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Pin synchronisers; stage 1 feeds only stage 2
    logic [1:0] rd_s_q, wr_s_q, strap_s1_q, strap_s2_q;
    logic rd_p_q, wr_p_q;
    logic [39:0] bus_s1_q, bus_s2_q;
    logic rd_fire, wr_fire;
    logic [3:0] addr;
    logic [3:0] lane_n;
    logic [31:0] data_in;
    bus_width_t width_q;
    logic [NUM_RW-1:0][15:0] regs_q;
    logic [15:0] bank_sel_q;
    logic [31:0] data_q;
    logic oe_q;
    logic [1:0] w;
    logic [3:0] m;
    logic [31:0] wd;
    logic [3:0] hidx [2];
    logic [31:0] rword, rm;
    logic [31:0] rdout;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_s_q <= 2'h3;
            wr_s_q <= 2'h3;
            rd_p_q <= 1'b1;
            wr_p_q <= 1'b1;
        end else begin
            rd_s_q <= {rd_s_q[0], host_rd_n_i};
            wr_s_q <= {wr_s_q[0], host_wr_n_i};
            rd_p_q <= rd_s_q[1];
            wr_p_q <= wr_s_q[1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        bus_s1_q <= {host_addr_i, byte_lane_select_n_i, host_data_i};
        bus_s2_q <= bus_s1_q;
        strap_s1_q <= {bus_is_32bit_i, host_bus_width_select_i};
        strap_s2_q <= strap_s1_q;
    end

    // Leading edge of each strobe; data must be set up by then
    assign rd_fire = rd_p_q & ~rd_s_q[1]; // see RULE7
    assign wr_fire = wr_p_q & ~wr_s_q[1]; // see RULE7
    assign addr = bus_s2_q[39:36];
    assign lane_n = bus_s2_q[35:32];
    assign data_in = bus_s2_q[31:0];

    // Width is caught while reset is held, so it cannot shift mid-access
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            if (strap_s2_q[1]) begin
                width_q <= BUS_32;
            end else if (strap_s2_q[0]) begin
                width_q <= BUS_16; // see RULE8
            end else begin
                width_q <= BUS_8; // see RULE8
            end
        end
    end

    // Every width lands on the same word/lane map, so offsets agree
    always_comb begin
        w = addr[3:2]; // see RULE5
        case (width_q)
            BUS_32: begin
                m = ~lane_n; // see RULE6
                wd = data_in;
            end
            BUS_16: begin
                m = addr[1] ? {~lane_n[1:0], 2'b00}
                            : {2'b00, ~lane_n[1:0]}; // see RULE4
                wd = {data_in[15:0], data_in[15:0]};
            end
            default: begin
                m = 4'h1 << addr[1:0]; // see RULE4
                wd = {4{data_in[7:0]}};
            end
        endcase
    end

    function automatic logic [3:0] lookup(input logic [15:0] bank,
                                          input logic [3:0] off);
        logic [3:0] idx;
        idx = IDX_NONE;
        case (bank)
            BANK_HOSTCFG: begin
                case (off)
                    OFF_B0_BASE_ADDR: idx = IDX_BASE;
                    OFF_B0_RX_WMARK: idx = IDX_WMARK;
                    OFF_B0_FAULT: idx = IDX_FAULT;
                    OFF_B0_BURST: idx = IDX_BURST;
                    default: idx = IDX_NONE;
                endcase
            end
            BANK_STATION: begin
                case (off)
                    OFF_B5_STA_LOW: idx = IDX_STA_LO;
                    OFF_B5_STA_MID: idx = IDX_STA_MID;
                    OFF_B5_STA_HIGH: idx = IDX_STA_HI;
                    default: idx = IDX_NONE;
                endcase
            end
            BANK_ONCHIP: begin
                case (off)
                    OFF_B6_OCB_CTRL: idx = IDX_OCB;
                    OFF_B6_SELFTEST: idx = IDX_SELFTEST;
                    OFF_B6_RST_CTRL: idx = IDX_RST;
                    OFF_B6_BUS_SETUP: idx = IDX_SETUP;
                    default: idx = IDX_NONE;
                endcase
            end
            default: idx = IDX_NONE;
        endcase
        return idx;
    endfunction : lookup

    // Decode follows the live selector: see RULE1
    assign hidx[0] = lookup(bank_sel_q, {w, 2'b00});
    assign hidx[1] = lookup(bank_sel_q, {w, 2'b10});

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            regs_q <= {NUM_RW{RST_REG}};
        end else if (wr_fire) begin
            for (int h = 0; h < 2; h++) begin
                for (int b = 0; b < 2; b++) begin
                    // Reserved and RO slots fall through untouched
                    if (hidx[h] < NUM_RW && m[2*h+b]) begin // see RULE9
                        regs_q[hidx[h]][8*b+:8] <= wd[16*h+8*b+:8];
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bank_sel_q <= RST_BANK_SEL;
        end else if (wr_fire && {w, 2'b10} == OFF_BANK_SEL) begin
            if (m[2]) begin
                bank_sel_q[7:0] <= wd[23:16]; // see RULE2
            end
            if (m[3]) begin
                bank_sel_q[15:8] <= wd[31:24]; // see RULE3
            end
        end
    end

    always_comb begin
        rword = 32'h0000_0000;
        for (int h = 0; h < 2; h++) begin
            if (h == 1 && {w, 2'b10} == OFF_BANK_SEL) begin
                rword[16*h+:16] = bank_sel_q; // see RULE2
            end else if (hidx[h] < NUM_RW) begin
                rword[16*h+:16] = regs_q[hidx[h]];
            end else if (hidx[h] == IDX_FAULT) begin
                rword[16*h+:16] = bus_fault_status_i;
            end else if (hidx[h] == IDX_SELFTEST) begin
                rword[16*h+:16] = memory_selftest_info_i;
            end
        end
        for (int b = 0; b < 4; b++) begin
            rm[8*b+:8] = m[b] ? rword[8*b+:8] : 8'h00; // see RULE4
        end
        case (width_q)
            BUS_32: rdout = rm; // see RULE6
            BUS_16: rdout = {16'h0000, addr[1] ? rm[31:16] : rm[15:0]};
            default: rdout = {24'h00_0000, rm[8*addr[1:0]+:8]};
        endcase
    end

    // Data is held for the whole strobe, not re-sampled
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_q <= 32'h0000_0000;
            oe_q <= 1'b0;
        end else begin
            if (rd_fire) begin
                data_q <= rdout; // see RULE7
            end
            oe_q <= ~rd_s_q[1];
        end
    end

    assign host_data_o = data_q;
    assign host_data_oe_o = oe_q;
    assign bank_selector_o = bank_sel_q;
    assign base_address_o = regs_q[IDX_BASE];
    assign rx_flow_watermark_o = regs_q[IDX_WMARK];
    assign bus_burst_size_o = regs_q[IDX_BURST];
    assign host_station_addr_o = {regs_q[IDX_STA_HI], regs_q[IDX_STA_MID],
                                  regs_q[IDX_STA_LO]};
    assign onchip_bus_control_o = regs_q[IDX_OCB];
    assign chip_reset_control_o = regs_q[IDX_RST];
    assign bus_setup_o = regs_q[IDX_SETUP];

    chk_sel_write: assert property ( // see RULE3
        wr_fire && w == 2'd3 && m[3:2] == 2'b11
        |=> bank_sel_q == $past(wd[31:16]))
        else $error("Selector write not taken");
    chk_sel_every_bank: assert property ( // see RULE2
        rd_fire && w == 2'd3 && width_q == BUS_32 && m == 4'hf
        |=> host_data_o[31:16] == $past(bank_sel_q))
        else $error("Selector not readable in current bank");
    chk_reserved_read: assert property ( // see RULE9
        rd_fire && w != 2'd3 && hidx[0] == IDX_NONE && hidx[1] == IDX_NONE
        |=> host_data_o == 32'h0000_0000)
        else $error("Reserved location read nonzero");
    chk_reserved_write: assert property ( // see RULE9
        wr_fire && w != 2'd3 && hidx[0] == IDX_NONE && hidx[1] == IDX_NONE
        |=> $stable(regs_q) && $stable(bank_sel_q))
        else $error("Reserved write changed state");
    chk_byte_lanes: assert property ( // see RULE4
        width_q == BUS_8 |-> $onehot(m))
        else $error("8-bit access touched several lanes");
    chk_half_lanes: assert property ( // see RULE8
        width_q == BUS_16 |-> m[3:2] == 2'b00 || m[1:0] == 2'b00)
        else $error("16-bit access spans both halves");
    chk_full_word: assert property ( // see RULE6
        wr_fire && w == 2'd0 && bank_sel_q == BANK_HOSTCFG
        && width_q == BUS_32 && m == 4'hf
        |=> base_address_o == $past(wd[15:0]))
        else $error("32-bit write lost");
    chk_bank_decode: assert property ( // see RULE1
        wr_fire && w == 2'd0 && bank_sel_q == BANK_STATION
        && m[1:0] == 2'b11
        |=> host_station_addr_o[15:0] == $past(wd[15:0])
            && $stable(base_address_o))
        else $error("Write decoded to wrong bank");
    chk_read_drive: assert property ( // see RULE7
        rd_fire |=> host_data_oe_o ##1 (host_data_oe_o == ~rd_s_q[1]))
        else $error("Read data not driven");
    chk_width_hold: assert property ( // see RULE5
        ##1 $stable(width_q))
        else $error("Bus width changed outside reset");

    cov_word_write: cover property (wr_fire && width_q == BUS_32
                                    && m == 4'hf);
    cov_byte_read: cover property (rd_fire && width_q == BUS_8);
    cov_bank_switch: cover property (wr_fire && w == 2'd3 ##[1:40]
                                     wr_fire && hidx[0] < NUM_RW);

endmodule : banked_io_register_window

`default_nettype wire

// File: pkg/banked_window_pkg.sv
/*
 * Constants for the banked host register window: byte offsets, bank
 * numbers, storage indices, reset values and the host bus width type.
 * Assumes a single internal clock domain and a synchronous chip reset.
 */
`default_nettype none

package banked_window_pkg;

    localparam int WIN_BYTES = 16;
    localparam int SYNC_STAGES = 2;

    // Bank numbers held in the selector
    localparam logic [15:0] BANK_HOSTCFG = 16'h0000;
    localparam logic [15:0] BANK_STATION = 16'h0005;
    localparam logic [15:0] BANK_ONCHIP = 16'h0006;

    // Byte offsets inside the sixteen-byte window
    localparam logic [3:0] OFF_B0_BASE_ADDR = 4'h0;
    localparam logic [3:0] OFF_B0_RX_WMARK = 4'h4;
    localparam logic [3:0] OFF_B0_FAULT = 4'h6;
    localparam logic [3:0] OFF_B0_BURST = 4'h8;
    localparam logic [3:0] OFF_B5_STA_LOW = 4'h0;
    localparam logic [3:0] OFF_B5_STA_MID = 4'h2;
    localparam logic [3:0] OFF_B5_STA_HIGH = 4'h4;
    localparam logic [3:0] OFF_B6_OCB_CTRL = 4'h0;
    localparam logic [3:0] OFF_B6_SELFTEST = 4'h4;
    localparam logic [3:0] OFF_B6_RST_CTRL = 4'h6;
    localparam logic [3:0] OFF_B6_BUS_SETUP = 4'h8;
    localparam logic [3:0] OFF_BANK_SEL = 4'he;

    // Storage indices; writable ones first
    localparam logic [3:0] IDX_BASE = 4'h0;
    localparam logic [3:0] IDX_WMARK = 4'h1;
    localparam logic [3:0] IDX_BURST = 4'h2;
    localparam logic [3:0] IDX_STA_LO = 4'h3;
    localparam logic [3:0] IDX_STA_MID = 4'h4;
    localparam logic [3:0] IDX_STA_HI = 4'h5;
    localparam logic [3:0] IDX_OCB = 4'h6;
    localparam logic [3:0] IDX_RST = 4'h7;
    localparam logic [3:0] IDX_SETUP = 4'h8;
    localparam logic [3:0] NUM_RW = 4'h9;
    localparam logic [3:0] IDX_FAULT = 4'h9;
    localparam logic [3:0] IDX_SELFTEST = 4'ha;
    localparam logic [3:0] IDX_NONE = 4'hf;

    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [15:0] RST_BANK_SEL = 16'h0000;

    typedef enum logic [1:0] {BUS_8, BUS_16, BUS_32} bus_width_t;

endpackage : banked_window_pkg

`default_nettype wire

// File: verif/host_cpu_model.sv
/* Host CPU model for the banked register window.
   Assumes the window answers a read within a dozen clocks. */
`default_nettype none
module host_cpu_model (
    input wire logic clk_i,
    input wire logic [31:0] rdata_i,
    input wire logic oe_i,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [3:0] addr_o,
    output logic [3:0] lanes_n_o,
    output logic [31:0] wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 4'h0;
        lanes_n_o = 4'hf;
        wdata_o = 32'h0;
    end
    // Lanes, address and data held for the whole strobe
    task automatic xfer(input logic wr, input logic [3:0] a,
        input logic [3:0] ln, input logic [31:0] d,
        output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk_i);
        addr_o <= a;
        lanes_n_o <= ln;
        wdata_o <= d;
        wr_n_o <= ~wr;
        rd_n_o <= wr;
        n = 0;
        repeat (4) @(posedge clk_i);
        while (!wr && oe_i !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        ok = wr || oe_i === 1'b1;
        q = rdata_i;
        // Released lines show the inverse, never the last value
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        addr_o <= ~a;
        lanes_n_o <= ~ln;
        wdata_o <= ~d;
        repeat (4) @(posedge clk_i);
    endtask : xfer
endmodule : host_cpu_model
`default_nettype wire

// File: verif/banked_io_register_window_bench.sv
/* Bench for the banked register window: three bus widths, window
   sweeps per bank, random accesses. Drives the host through the model. */
`default_nettype none
module banked_io_register_window_bench;
    import banked_window_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic w16 = 1'b1;
    logic w32 = 1'b1;
    logic [15:0] fault = 16'h0, stest = 16'h0, sel_m;
    logic rd_n, wr_n, oe;
    logic [3:0] addr, lanes;
    logic [31:0] wd, rdq;
    logic [15:0] sel_o, base_o, wm_o, burst_o, ocb_o, rctl_o, setup_o;
    logic [47:0] sta_o;
    logic [15:0] sh [0:7][0:7];
    int miscompares = 0, n_checks = 0, cycles = 0, width = 2;

    host_cpu_model host (.clk_i(ref_clk), .rdata_i(rdq), .oe_i(oe),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .lanes_n_o(lanes),
        .wdata_o(wd));
    banked_io_register_window DUT (.ref_clk_i(ref_clk), .rst_i(rst),
        .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_addr_i(addr),
        .byte_lane_select_n_i(lanes), .host_data_i(wd),
        .host_data_o(rdq), .host_data_oe_o(oe),
        .host_bus_width_select_i(w16), .bus_is_32bit_i(w32),
        .bus_fault_status_i(fault), .memory_selftest_info_i(stest),
        .bank_selector_o(sel_o), .base_address_o(base_o),
        .rx_flow_watermark_o(wm_o), .bus_burst_size_o(burst_o),
        .host_station_addr_o(sta_o), .onchip_bus_control_o(ocb_o),
        .chip_reset_control_o(rctl_o), .bus_setup_o(setup_o));

    always #2 ref_clk = ~ref_clk;

    function automatic bit wr_ok(logic [15:0] b, logic [2:0] w);
        return (b == BANK_HOSTCFG && w inside {3'd0, 3'd2, 3'd4}) ||
            (b == BANK_STATION && w < 3'd3) ||
            (b == BANK_ONCHIP && w inside {3'd0, 3'd3, 3'd4});
    endfunction : wr_ok

    function automatic logic [7:0] rd_byte(logic [3:0] o);
        logic [15:0] v;
        v = wr_ok(sel_m, o[3:1]) ? sh[sel_m[2:0]][o[3:1]] : 16'h0;
        if (o[3:1] == 3'd7) v = sel_m;
        if (sel_m == BANK_HOSTCFG && o[3:1] == 3'd3) v = fault;
        if (sel_m == BANK_ONCHIP && o[3:1] == 3'd2) v = stest;
        return v[8*o[0] +: 8];
    endfunction : rd_byte

    task automatic cmp(input string nm, input logic [47:0] e,
        input logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic op(input logic wr, input logic [3:0] a,
        input logic [3:0] ln, input logic [31:0] d);
        logic [31:0] q, e;
        logic ok, on;
        logic [3:0] o, b;
        host.xfer(wr, a, ln, d, q, ok);
        e = 32'h0;
        b = width == 2 ? {a[3:2], 2'b00} : width == 1 ? {a[3:1], 1'b0} : a;
        for (int i = 0; i < (1 << width); i++) begin
            o = b + 4'(i);
            on = width == 0 || !ln[i];
            if (on && wr && o[3:1] == 3'd7) sel_m[8*o[0] +: 8] = d[8*i +: 8];
            else if (on && wr && wr_ok(sel_m, o[3:1]))
                sh[sel_m[2:0]][o[3:1]][8*o[0] +: 8] = d[8*i +: 8];
            else if (on && !wr) e[8*i +: 8] = rd_byte(o);
        end
        if (!wr) begin
            cmp("read_data", e, q);
            cmp("read_ack", 48'h1, ok);
            cmp("oe_idle", 48'h0, oe);
        end
    endtask : op

    // Host writes the selector before going to another bank
    task automatic set_bank(input logic [15:0] b);
        if (width == 0) begin
            op(1'b1, 4'he, 4'h0, {24'h0, b[7:0]});
            op(1'b1, 4'hf, 4'h0, {24'h0, b[15:8]});
        end else op(1'b1, 4'he, 4'h0, {b, b});
    endtask : set_bank

    task automatic check_outs;
        cmp("bank_sel", sel_m, sel_o);
        cmp("base", sh[0][0], base_o);
        cmp("wmark", sh[0][2], wm_o);
        cmp("burst", sh[0][4], burst_o);
        cmp("station", {sh[5][2], sh[5][1], sh[5][0]}, sta_o);
        cmp("ocb", sh[6][0], ocb_o);
        cmp("rst_ctl", sh[6][3], rctl_o);
        cmp("setup", sh[6][4], setup_o);
    endtask : check_outs

    task automatic phase(input int w);
        logic [15:0] banks [5] = '{BANK_HOSTCFG, BANK_STATION, BANK_ONCHIP,
            16'h0001, 16'h0007};
        width = w;
        @(posedge ref_clk);
        rst <= 1'b1;
        w32 <= w == 2;
        w16 <= w == 1;
        fault <= 16'($urandom);
        stest <= 16'($urandom);
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        sel_m = RST_BANK_SEL;
        foreach (sh[i, j]) sh[i][j] = RST_REG;
        check_outs();
        cmp("oe_reset", 48'h0, oe);
        cmp("rdata_reset", 48'h0, rdq);
        foreach (banks[k]) begin
            set_bank(banks[k]);
            // Stop short of the selector so the sweep stays in this bank
            for (int o = 0; o < (w == 2 ? 12 : 14); o += (1 << w)) begin
                op(1'b1, 4'(o), 4'h0, $urandom);
                op(1'b0, 4'(o), 4'h0, 32'h0);
            end
            op(1'b0, 4'he, 4'h0, 32'h0);
        end
        repeat (40) begin
            if ($urandom_range(7) == 0) begin
                set_bank(banks[$urandom_range(4)]);
            end
            op(1'($urandom), 4'($urandom), 4'($urandom), $urandom);
        end
        check_outs();
    endtask : phase

    task automatic report_and_stop;
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(32'h71bd84fc));
        phase(2);
        phase(1);
        phase(0);
        report_and_stop();
    end
endmodule : banked_io_register_window_bench
`default_nettype wire
